// ==== rtl/trah_defs.vh ====
// Operation
// - Command bit 7 set marks a register access, not process data.
// - Command bit 6 selects direction: one writes, zero reads.
// - Command bits 5..0 carry the six-bit register number.
// - Write is acknowledged with the command byte, bit 6 cleared.
// - Read is acknowledged with the unchanged command byte.
// - Read returns the addressed register contents in the input word.
// - Host output word is ignored during a read.
// - Write stores the host output word into the addressed register.
// - Byte 0 command or reply, byte 1 data high, byte 2 data low.
// - Writing zero to register 31 re-enables write protection.
// - Register 32 holds the type-specific feature bits.
// - Protection lifts only while register 31 holds 0x1235.
// - Without the code word, registers other than 31 reject writes.
// - Changed values reach terminal behaviour only after a restart; the code word in register 31 applies from the next cycle.
// - Command or reply byte at lowest channel address, data follows.
`ifndef TRAH_DEFS_VH
`define TRAH_DEFS_VH

// ----------------------------------------
// Control byte fields
// ----------------------------------------
`define TRAH_CB_REGACC     7
`define TRAH_CB_WRITE      6
`define TRAH_CB_NUM_HI     5
`define TRAH_CB_NUM_LO     0

// ----------------------------------------
// Register numbers and values
// ----------------------------------------
`define TRAH_REG_UNLOCK    6'h1F
`define TRAH_REG_FEATURE   6'h20
`define TRAH_UNLOCK_CODE   16'h1235
`define TRAH_UNLOCK_RST    16'h0000
`define TRAH_FEATURE_RST   16'h0000
`define TRAH_NUM_REGS      64

`endif

// ==== rtl/trah_reg_file.v ====
`timescale 1ns/100ps
module trah_reg_file (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        wr_en,
  input  wire [5:0]  wr_num,
  input  wire [15:0] wr_data,
  input  wire [5:0]  rd_num,
  output reg  [15:0] rd_data,
  output reg         unlocked,
  output reg  [15:0] feature_cur
);
`include "trah_defs.vh"

  reg [15:0] mem [0:`TRAH_NUM_REGS-1];
  reg [15:0] unlock_ff;
  reg [15:0] feature_ff;

  // ----------------------------------------
  // General user registers
  // ----------------------------------------
  // Plain storage, no reset needed
  always @(posedge clk) begin
    if (wr_en) begin
      mem[wr_num] <= wr_data;
    end
  end

  // ----------------------------------------
  // Code word and feature registers
  // ----------------------------------------
  // Code word relocks at every restart
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      unlock_ff <= `TRAH_UNLOCK_RST;
    end else if (wr_en && wr_num == `TRAH_REG_UNLOCK) begin
      unlock_ff <= wr_data;
    end
  end

  // Feature word survives restarts, like stored settings
  always @(posedge clk) begin
    if (wr_en && wr_num == `TRAH_REG_FEATURE) begin
      feature_ff <= wr_data;
    end
  end

  // Read mux and protection state
  always @* begin
    if (rd_num == `TRAH_REG_UNLOCK) begin
      rd_data = unlock_ff;
    end else if (rd_num == `TRAH_REG_FEATURE) begin
      rd_data = feature_ff;
    end else begin
      rd_data = mem[rd_num];
    end
    unlocked    = (unlock_ff == `TRAH_UNLOCK_CODE);
    feature_cur = feature_ff;
  end

endmodule

// ==== rtl/trah_terminal.v ====
`timescale 1ns/100ps
module trah_terminal (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        cycle_strobe,
  input  wire [7:0]  out_byte0,
  input  wire [7:0]  out_byte1,
  input  wire [7:0]  out_byte2,
  output reg  [7:0]  in_byte0,
  output reg  [7:0]  in_byte1,
  output reg  [7:0]  in_byte2,
  output reg         pd_valid,
  output reg  [7:0]  pd_ctrl,
  output reg  [15:0] pd_out_word,
  input  wire [7:0]  pd_status,
  input  wire [15:0] pd_in_word,
  output reg  [15:0] feature_active
);
`include "trah_defs.vh"

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  reg        rst_s1_ff;
  reg        rst_s2_ff;
  wire       rst_int_n;

  // Two-stage reset release
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_ff <= 1'b0;
      rst_s2_ff <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_s2_ff <= rst_s1_ff;
    end
  end
  assign rst_int_n = rst_s2_ff;

  // First cycle after internal release marker
  reg        rst_done_ff;
  always @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      rst_done_ff <= 1'b0;
    end else begin
      rst_done_ff <= 1'b1;
    end
  end

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  // Register access requested by a command byte
  function trah_is_reg;
    input [7:0] cb;
    begin
      trah_is_reg = cb[`TRAH_CB_REGACC];
    end
  endfunction

  // Register access in write direction
  function trah_is_write;
    input [7:0] cb;
    begin
      trah_is_write = cb[`TRAH_CB_REGACC] & cb[`TRAH_CB_WRITE];
    end
  endfunction

  // Receipt byte, direction bit always cleared
  function [7:0] trah_receipt;
    input [7:0] cb;
    begin
      trah_receipt                 = cb;
      trah_receipt[`TRAH_CB_WRITE] = 1'b0;
    end
  endfunction

  // Six-bit register number field
  function [5:0] trah_reg_num;
    input [7:0] cb;
    begin
      trah_reg_num = cb[`TRAH_CB_NUM_HI:`TRAH_CB_NUM_LO];
    end
  endfunction

  // Code word register always open, the rest need the code
  function trah_may_write;
    input [5:0] num;
    input       code_ok;
    begin
      trah_may_write = (num == `TRAH_REG_UNLOCK) || code_ok;
    end
  endfunction

  // Upper byte of a data word
  function [7:0] trah_hi;
    input [15:0] w;
    begin
      trah_hi = w[15:8];
    end
  endfunction

  // Lower byte of a data word
  function [7:0] trah_lo;
    input [15:0] w;
    begin
      trah_lo = w[7:0];
    end
  endfunction

  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  wire [7:0]  cmd             = out_byte0;
  wire [15:0] host_write_word = {out_byte1, out_byte2};
  wire        is_reg          = trah_is_reg(cmd);
  wire        is_write        = trah_is_write(cmd);
  wire [5:0]  reg_num         = trah_reg_num(cmd);
  wire        take_reg        = cycle_strobe & is_reg;
  wire        take_pd         = cycle_strobe & ~is_reg;
  wire [15:0] rd_data;
  wire        unlocked;
  wire [15:0] feature_cur;
  reg         wr_en;

  // Write gating by protection
  always @* begin
    wr_en = 1'b0;
    if (take_reg && is_write) begin
      if (trah_may_write(reg_num, unlocked)) begin
        wr_en = 1'b1;
      end
    end
  end

  trah_reg_file u_regs (
    .clk         (clk),
    .rst_n       (rst_int_n),
    .wr_en       (wr_en),
    .wr_num      (reg_num),
    .wr_data     (host_write_word),
    .rd_num      (reg_num),
    .rd_data     (rd_data),
    .unlocked    (unlocked),
    .feature_cur (feature_cur)
  );

  // ----------------------------------------
  // Reply and process data next values
  // ----------------------------------------
  reg [7:0]  nxt_in_byte0;
  reg [7:0]  nxt_in_byte1;
  reg [7:0]  nxt_in_byte2;
  reg        nxt_pd_valid;
  reg [7:0]  nxt_pd_ctrl;
  reg [15:0] nxt_pd_out_word;

  // Reply held until the next exchange cycle
  always @* begin
    nxt_in_byte0    = in_byte0;
    nxt_in_byte1    = in_byte1;
    nxt_in_byte2    = in_byte2;
    nxt_pd_valid    = 1'b0;
    nxt_pd_ctrl     = pd_ctrl;
    nxt_pd_out_word = pd_out_word;
    if (take_reg) begin
      nxt_in_byte0 = trah_receipt(cmd);
      if (is_write) begin
        nxt_in_byte1 = 8'h00;
        nxt_in_byte2 = 8'h00;
      end else begin
        nxt_in_byte1 = trah_hi(rd_data);
        nxt_in_byte2 = trah_lo(rd_data);
      end
    end else if (take_pd) begin
      nxt_pd_valid    = 1'b1;
      nxt_pd_ctrl     = cmd;
      nxt_pd_out_word = host_write_word;
      nxt_in_byte0    = pd_status;
      nxt_in_byte1    = trah_hi(pd_in_word);
      nxt_in_byte2    = trah_lo(pd_in_word);
    end
  end

  // ----------------------------------------
  // Output registers
  // ----------------------------------------
  // Reply bytes seen by the host
  always @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      in_byte0 <= 8'h00;
      in_byte1 <= 8'h00;
      in_byte2 <= 8'h00;
    end else begin
      in_byte0 <= nxt_in_byte0;
      in_byte1 <= nxt_in_byte1;
      in_byte2 <= nxt_in_byte2;
    end
  end

  // Process data handed to the application
  always @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      pd_valid    <= 1'b0;
      pd_ctrl     <= 8'h00;
      pd_out_word <= 16'h0000;
    end else begin
      pd_valid    <= nxt_pd_valid;
      pd_ctrl     <= nxt_pd_ctrl;
      pd_out_word <= nxt_pd_out_word;
    end
  end

  // ----------------------------------------
  // Restart behaviour
  // ----------------------------------------
  // Feature bits latched only at restart
  always @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      feature_active <= `TRAH_FEATURE_RST;
    end else if (!rst_done_ff) begin
      feature_active <= feature_cur;
    end
  end

endmodule

// ==== bench/trah_chk.sv ====
`timescale 1ns/100ps
module trah_chk (
  input wire       clk,
  input wire       rst_n,
  input wire       cycle_strobe,
  input wire [7:0] out_byte0,
  input wire [7:0] out_byte1,
  input wire [7:0] out_byte2,
  input wire [7:0] in_byte0,
  input wire [7:0] in_byte1,
  input wire [7:0] in_byte2,
  input wire       pd_valid
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // Decoded host requests
  wire        wr = cycle_strobe && out_byte0[7] && out_byte0[6];
  wire        rd = cycle_strobe && out_byte0[7] && !out_byte0[6];
  wire [15:0] ow = {out_byte1, out_byte2};
  wire [15:0] iw = {in_byte1, in_byte2};
  // Code word writes to register 31 and its read-back
  sequence unlock_s;
    wr && out_byte0[5:0] == 6'h1F && ow == 16'h1235;
  endsequence
  sequence relock_s;
    wr && out_byte0[5:0] == 6'h1F && ow == 16'h0000;
  endsequence
  sequence rd31_s;
    cycle_strobe && out_byte0 == 8'h9F;
  endsequence
  wr_ack_a: assert property (wr |=> in_byte0 == ($past(out_byte0) & 8'hBF))
    else $error("write reply wrong");
  wr_word_a: assert property (wr |=> iw == 16'h0000)
    else $error("write reply word not zero");
  rd_ack_a: assert property (rd |=> in_byte0 == $past(out_byte0))
    else $error("read reply wrong");
  pd_pass_a: assert property (cycle_strobe && !out_byte0[7] |=> pd_valid)
    else $error("process data not passed");
  pd_only_a: assert property (pd_valid |-> $past(cycle_strobe && !out_byte0[7]))
    else $error("spurious process data pulse");
  reply_hold_a: assert property (!cycle_strobe |=> $stable(iw))
    else $error("reply word changed without strobe");
  unlock_rd_a: assert property (unlock_s ##1 rd31_s |=> iw == 16'h1235)
    else $error("code word not read back");
  relock_rd_a: assert property (relock_s ##1 rd31_s |=> iw == 16'h0000)
    else $error("cleared code word not read back");
endmodule

// ==== bench/trah_host_model.sv ====
`timescale 1ns/100ps
module trah_host_model (
  input  wire       clk,
  output reg        strobe,
  output reg  [7:0] b0,
  output reg  [7:0] b1,
  output reg  [7:0] b2
);
  // Idle process image at time zero
  initial begin
    strobe = 1'h0;
    b0 = 8'h00;
    b1 = 8'h00;
    b2 = 8'h00;
  end
  // One exchange; read data bytes toggle as they mean nothing
  task xfer(input [7:0] cmd, input [15:0] word);
    begin
      @(negedge clk);
      strobe = 1'h1;
      b0 = cmd;
      b1 = cmd[6] ? word[15:8] : ~b1;
      b2 = cmd[6] ? word[7:0] : ~b2;
    end
  endtask
  // End of exchanges; reply word after writes is checked for zero by wr_word_a, not here
  task idle;
    begin
      @(negedge clk);
      strobe = 1'h0;
    end
  endtask
endmodule

// ==== bench/trah_terminal_bench.sv ====
`timescale 1ns/100ps
module trah_terminal_bench;
  reg         clk;
  reg         rst_n;
  wire        stb;
  wire        pd_valid;
  wire [7:0]  b0, b1, b2, i0, i1, i2, pd_ctrl;
  wire [15:0] pd_out_word, feature_active;
  integer     errors, checked;
  trah_host_model u_host (.clk(clk), .strobe(stb), .b0(b0), .b1(b1), .b2(b2));
  trah_terminal dut (.clk(clk), .rst_n(rst_n), .cycle_strobe(stb),
    .out_byte0(b0), .out_byte1(b1), .out_byte2(b2), .in_byte0(i0),
    .in_byte1(i1), .in_byte2(i2), .pd_valid(pd_valid), .pd_ctrl(pd_ctrl),
    .pd_out_word(pd_out_word), .pd_status(8'h5A), .pd_in_word(16'hC3E1),
    .feature_active(feature_active));
  // Clock
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end
  task check(input [15:0] seen, input [15:0] want);
    begin
      checked = checked + 1;
      if (seen !== want) begin
        errors = errors + 1;
        $display("mismatch at %0t: saw %h want %h", $time, seen, want);
      end
    end
  endtask
  task acc(input [7:0] cmd, input [15:0] word);
    begin
      u_host.xfer(cmd, word);
      u_host.idle;
    end
  endtask
  task end_of_test;
    begin
      $display("errors %0d checked %0d", errors, checked);
      if (errors == 0 && checked > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  // Watchdog
  initial begin
    #100000;
    errors = errors + 1;
    end_of_test;
  end
  // Restart: reset pulse, then wait out the internal release
  task restart;
    begin
      @(negedge clk);
      rst_n = 1'h0;
      repeat (16) @(negedge clk);
      rst_n = 1'h1;
      repeat (3) @(negedge clk);
    end
  endtask
  // Access sequence
  initial begin
    errors = 0;
    checked = 0;
    rst_n = 1'h0;
    repeat (16) @(negedge clk);
    rst_n = 1'h1;
    repeat (3) @(negedge clk);
    acc(8'h60, 16'h1357);
    check(pd_valid, 16'h0001);
    check(pd_out_word, 16'h1357);
    check(pd_ctrl, 16'h0060);
    check({i1, i2}, 16'hC3E1);
    check(i0, 16'h005A);
    acc(8'hE0, 16'h0002);
    check(i0, 16'h00A0);
    u_host.xfer(8'hDF, 16'h1235);
    acc(8'h9F, 16'h0000);
    check(i0, 16'h009F);
    check({i1, i2}, 16'h1235);
    acc(8'hE0, 16'h0002);
    acc(8'hA0, 16'h0000);
    check({i1, i2}, 16'h0002);
    acc(8'hC5, 16'hABCD);
    acc(8'h85, 16'h0000);
    check({i1, i2}, 16'hABCD);
    u_host.xfer(8'hDF, 16'h0000);
    acc(8'h9F, 16'h0000);
    check({i1, i2}, 16'h0000);
    acc(8'hC5, 16'h1111);
    acc(8'h85, 16'h0000);
    check({i1, i2}, 16'hABCD);
    acc(8'hE0, 16'h0007);
    acc(8'hA0, 16'h0000);
    check({i1, i2}, 16'h0002);
    restart;
    check(feature_active, 16'h0002);
    acc(8'h9F, 16'h0000);
    check({i1, i2}, 16'h0000);
    u_host.xfer(8'hDF, 16'h1235);
    acc(8'hE0, 16'h0005);
    acc(8'hA0, 16'h0000);
    check({i1, i2}, 16'h0005);
    check(feature_active, 16'h0002);
    end_of_test;
  end
endmodule
bind trah_terminal trah_chk u_chk (.clk(clk), .rst_n(rst_n),
  .cycle_strobe(cycle_strobe), .out_byte0(out_byte0), .out_byte1(out_byte1),
  .out_byte2(out_byte2), .in_byte0(in_byte0), .in_byte1(in_byte1),
  .in_byte2(in_byte2), .pd_valid(pd_valid));
